// ### hw/ccr_pkg.sv
// Constants for the comparator control register bank.
// Assumes an 8-bit special-function register bus with page select.
`default_nettype none

package ccr_pkg;

  // Register addresses and page
  localparam logic [7:0] ADDR_CTRL = 8'h9B;
  localparam logic [7:0] ADDR_MODE = 8'h9D;
  localparam logic [7:0] PAGE_CTRL = 8'h00;

  // Control register fields
  localparam int CTRL_ON_BIT = 7;
  localparam int CTRL_RESULT_BIT = 6;
  localparam int CTRL_RISE_BIT = 5;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_UPHYS_HI = 3;
  localparam int CTRL_UPHYS_LO = 2;
  localparam int CTRL_LOHYS_HI = 1;
  localparam int CTRL_LOHYS_LO = 0;

  // Mode register fields
  localparam int MODE_RSVD_BIT = 7;
  localparam int MODE_RISE_IE_BIT = 5;
  localparam int MODE_FALL_IE_BIT = 4;
  localparam int MODE_SPEED_HI = 1;
  localparam int MODE_SPEED_LO = 0;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h82;
  localparam logic [1:0] SPEED_RESET = 2'h2;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Hysteresis codes and their amounts in millivolts
  localparam logic [1:0] HYS_OFF = 2'h0;
  localparam logic [1:0] HYS_SMALL = 2'h1;
  localparam logic [1:0] HYS_MID = 2'h2;
  localparam logic [1:0] HYS_TOP = 2'h3;
  localparam logic [4:0] HYS_MV_OFF = 5'h00;
  localparam logic [4:0] HYS_MV_SMALL = 5'h05;
  localparam logic [4:0] HYS_MV_MID = 5'h0A;
  localparam logic [4:0] HYS_MV_TOP_UPPER = 5'h0A;
  localparam logic [4:0] HYS_MV_TOP_LOWER = 5'h14;

  // Comparator power condition
  typedef enum logic {
    PWR_OFF,
    PWR_ON
  } ccr_pwr_t;

endpackage : ccr_pkg

`default_nettype wire

// ### hw/ccr_sync.sv
// Two-flop synchroniser for the raw comparator output.
// Assumes the input may change at any time relative to the clock.
`default_nettype none
`timescale 1ns/1ps

module ccr_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;
  logic sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule : ccr_sync

`default_nettype wire

// ### hw/ccr_top.sv
// Control and status register bank for one voltage comparator.
// Assumes the processor's register bus with address, page and strobes,
// and an analog comparator core whose output is asynchronous.
//
// Behaviour
// - Clearing the on bit turns the comparator off into low power.
// - Result bit 6 is read-only: 1 when positive input above negative.
// - Rise flag bit 5 sets on a 0-to-1 output change, software clears.
// - Fall flag bit 4 sets on a 1-to-0 output change, software clears.
// - Upper hysteresis code bits 3-2: off, 5 mV, 10 mV, 10 mV.
// - Lower hysteresis code bits 1-0: off, 5 mV, 10 mV, 20 mV.
// - Upper hysteresis delays the rising output by the programmed amount.
// - Lower hysteresis delays the falling output by the programmed amount.
// - Mode bit 5 enables the rise interrupt.
// - Mode bit 4 enables the fall interrupt.
// - Mode bits 1:0 pick response speed, 00 fastest, 11 lowest power.
// - Mode bit 7 reads 1; software always writes 1 there.
// - Mode bits 6, 3, 2 read zero and ignore writes.
// - Mode register answers at 0x9D on every page.
// - Control register answers at 0x9B only on page 0.
// - Edge flags set regardless of interrupt enables.
// - Output seen by the logic is 0 while the comparator is off.
// - Comparator output is synchronised before any use.
`default_nettype none
`timescale 1ns/1ps

module ccr_top (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic [7:0] SFR_PAGE_IN,
  input wire logic SFR_WR_IN,
  input wire logic SFR_RD_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  input wire logic CMP_RAW_IN,
  output logic [7:0] SFR_RDATA_OUT,
  output logic CMP_ENABLE_OUT,
  output logic CMP_POWER_DOWN_OUT,
  output logic [1:0] UPPER_HYST_CODE_OUT,
  output logic [1:0] LOWER_HYST_CODE_OUT,
  output logic [4:0] UPPER_HYST_MV_OUT,
  output logic [4:0] LOWER_HYST_MV_OUT,
  output logic [1:0] RESPONSE_SPEED_OUT,
  output logic CMP_SYNC_OUT,
  output logic IRQ_OUT
);

  // Hysteresis code to millivolts; upper code 11 stays at 10 mV
  function automatic logic [4:0] hyst_mv(input logic [1:0] code, input logic upper);
    logic [4:0] mv;
    mv = ccr_pkg::HYS_MV_OFF;
    case (code)
      ccr_pkg::HYS_OFF: mv = ccr_pkg::HYS_MV_OFF;
      ccr_pkg::HYS_SMALL: mv = ccr_pkg::HYS_MV_SMALL;
      ccr_pkg::HYS_MID: mv = ccr_pkg::HYS_MV_MID;
      ccr_pkg::HYS_TOP: mv = upper ? ccr_pkg::HYS_MV_TOP_UPPER : ccr_pkg::HYS_MV_TOP_LOWER;
      default: mv = ccr_pkg::HYS_MV_OFF;
    endcase
    return mv;
  endfunction : hyst_mv

  // Address decode shared by the read and write paths
  function automatic logic hit_ctrl(input logic [7:0] addr, input logic [7:0] page);
    return (addr == ccr_pkg::ADDR_CTRL) && (page == ccr_pkg::PAGE_CTRL);
  endfunction : hit_ctrl

  // Mode register ignores the page select
  function automatic logic hit_mode(input logic [7:0] addr);
    return addr == ccr_pkg::ADDR_MODE;
  endfunction : hit_mode

  // Register state
  logic on_r;
  logic on_nxt;
  ccr_pkg::ccr_pwr_t pwr_r;
  ccr_pkg::ccr_pwr_t pwr_nxt;
  logic pd_r;
  logic rise_flag_r;
  logic rise_flag_nxt;
  logic fall_flag_r;
  logic fall_flag_nxt;
  logic [1:0] upper_hys_r;
  logic [1:0] upper_hys_nxt;
  logic [1:0] lower_hys_r;
  logic [1:0] lower_hys_nxt;
  logic [4:0] upper_mv_r;
  logic [4:0] lower_mv_r;
  logic rise_ie_r;
  logic rise_ie_nxt;
  logic fall_ie_r;
  logic fall_ie_nxt;
  logic [1:0] speed_r;
  logic [1:0] speed_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_r;

  // Comparator path state
  logic cmp_sync;
  logic seen_r;
  logic seen_prev_r;
  logic rise_evt;
  logic fall_evt;

  // Decoded strobes
  logic ctrl_wr;
  logic mode_wr;
  logic ctrl_rd;
  logic mode_rd;
  logic [7:0] ctrl_view;
  logic [7:0] mode_view;

  ccr_sync u_sync (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .async_in(CMP_RAW_IN),
    .sync_out(cmp_sync)
  );

  // Strobe decode
  assign ctrl_wr = SFR_WR_IN && hit_ctrl(SFR_ADDR_IN, SFR_PAGE_IN);
  assign mode_wr = SFR_WR_IN && hit_mode(SFR_ADDR_IN);
  assign ctrl_rd = SFR_RD_IN && hit_ctrl(SFR_ADDR_IN, SFR_PAGE_IN);
  assign mode_rd = SFR_RD_IN && hit_mode(SFR_ADDR_IN);

  // Gated: an off comparator reads 0 even if the core glitches
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      seen_r <= 1'b0;
      seen_prev_r <= 1'b0;
    end else begin
      seen_r <= cmp_sync && on_r;
      seen_prev_r <= seen_r;
    end
  end

  assign rise_evt = seen_r && !seen_prev_r;
  assign fall_evt = !seen_r && seen_prev_r;

  // Enable bit
  always_comb begin
    on_nxt = on_r;
    if (ctrl_wr) begin
      on_nxt = SFR_WDATA_IN[ccr_pkg::CTRL_ON_BIT];
    end
  end

  // Power condition follows the enable bit
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      ccr_pkg::PWR_OFF: begin
        if (on_nxt) begin
          pwr_nxt = ccr_pkg::PWR_ON;
        end
      end
      ccr_pkg::PWR_ON: begin
        if (!on_nxt) begin
          pwr_nxt = ccr_pkg::PWR_OFF;
        end
      end
      default: begin
        pwr_nxt = ccr_pkg::PWR_OFF;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      on_r <= 1'b0;
    end else begin
      on_r <= on_nxt;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pwr_r <= ccr_pkg::PWR_OFF;
      pd_r <= 1'b1;
    end else begin
      pwr_r <= pwr_nxt;
      pd_r <= (pwr_nxt == ccr_pkg::PWR_OFF);
    end
  end

  // Edge flags; a detected edge beats a software clear in the same cycle
  always_comb begin
    rise_flag_nxt = rise_flag_r;
    if (rise_evt) begin
      rise_flag_nxt = 1'b1;
    end else if (ctrl_wr) begin
      rise_flag_nxt = SFR_WDATA_IN[ccr_pkg::CTRL_RISE_BIT];
    end
  end

  always_comb begin
    fall_flag_nxt = fall_flag_r;
    if (fall_evt) begin
      fall_flag_nxt = 1'b1;
    end else if (ctrl_wr) begin
      fall_flag_nxt = SFR_WDATA_IN[ccr_pkg::CTRL_FALL_BIT];
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rise_flag_r <= 1'b0;
    end else begin
      rise_flag_r <= rise_flag_nxt;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fall_flag_r <= 1'b0;
    end else begin
      fall_flag_r <= fall_flag_nxt;
    end
  end

  // Hysteresis codes; the analog core applies the band itself
  always_comb begin
    upper_hys_nxt = upper_hys_r;
    lower_hys_nxt = lower_hys_r;
    if (ctrl_wr) begin
      upper_hys_nxt = SFR_WDATA_IN[ccr_pkg::CTRL_UPHYS_HI:ccr_pkg::CTRL_UPHYS_LO];
      lower_hys_nxt = SFR_WDATA_IN[ccr_pkg::CTRL_LOHYS_HI:ccr_pkg::CTRL_LOHYS_LO];
    end
  end

  // Millivolt outputs follow the next code so they change with it
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      upper_hys_r <= ccr_pkg::HYS_OFF;
      upper_mv_r <= ccr_pkg::HYS_MV_OFF;
    end else begin
      upper_hys_r <= upper_hys_nxt;
      upper_mv_r <= hyst_mv(upper_hys_nxt, 1'b1);
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lower_hys_r <= ccr_pkg::HYS_OFF;
      lower_mv_r <= ccr_pkg::HYS_MV_OFF;
    end else begin
      lower_hys_r <= lower_hys_nxt;
      lower_mv_r <= hyst_mv(lower_hys_nxt, 1'b0);
    end
  end

  // Mode register; reserved and unused bits are not stored
  always_comb begin
    rise_ie_nxt = rise_ie_r;
    fall_ie_nxt = fall_ie_r;
    speed_nxt = speed_r;
    if (mode_wr) begin
      rise_ie_nxt = SFR_WDATA_IN[ccr_pkg::MODE_RISE_IE_BIT];
      fall_ie_nxt = SFR_WDATA_IN[ccr_pkg::MODE_FALL_IE_BIT];
      speed_nxt = SFR_WDATA_IN[ccr_pkg::MODE_SPEED_HI:ccr_pkg::MODE_SPEED_LO];
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rise_ie_r <= 1'b0;
      fall_ie_r <= 1'b0;
    end else begin
      rise_ie_r <= rise_ie_nxt;
      fall_ie_r <= fall_ie_nxt;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      speed_r <= ccr_pkg::SPEED_RESET;
    end else begin
      speed_r <= speed_nxt;
    end
  end

  // Read views
  always_comb begin
    ctrl_view = ccr_pkg::CTRL_RESET;
    ctrl_view[ccr_pkg::CTRL_ON_BIT] = on_r;
    ctrl_view[ccr_pkg::CTRL_RESULT_BIT] = seen_r;
    ctrl_view[ccr_pkg::CTRL_RISE_BIT] = rise_flag_r;
    ctrl_view[ccr_pkg::CTRL_FALL_BIT] = fall_flag_r;
    ctrl_view[ccr_pkg::CTRL_UPHYS_HI:ccr_pkg::CTRL_UPHYS_LO] = upper_hys_r;
    ctrl_view[ccr_pkg::CTRL_LOHYS_HI:ccr_pkg::CTRL_LOHYS_LO] = lower_hys_r;
  end

  always_comb begin
    mode_view = ccr_pkg::UNMAPPED_READ;
    mode_view[ccr_pkg::MODE_RSVD_BIT] = ccr_pkg::MODE_RESET[ccr_pkg::MODE_RSVD_BIT];
    mode_view[ccr_pkg::MODE_RISE_IE_BIT] = rise_ie_r;
    mode_view[ccr_pkg::MODE_FALL_IE_BIT] = fall_ie_r;
    mode_view[ccr_pkg::MODE_SPEED_HI:ccr_pkg::MODE_SPEED_LO] = speed_r;
  end

  // Read data is registered; unmapped reads return zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (ctrl_rd) begin
      rdata_nxt = ctrl_view;
    end else if (mode_rd) begin
      rdata_nxt = mode_view;
    end else if (SFR_RD_IN) begin
      rdata_nxt = ccr_pkg::UNMAPPED_READ;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_r <= ccr_pkg::UNMAPPED_READ;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Interrupt request; the global enable lives outside
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (rise_flag_r && rise_ie_r) || (fall_flag_r && fall_ie_r);
    end
  end

  // Outputs straight from flops
  assign SFR_RDATA_OUT = rdata_r;
  assign CMP_ENABLE_OUT = on_r;
  assign CMP_POWER_DOWN_OUT = pd_r;
  assign UPPER_HYST_CODE_OUT = upper_hys_r;
  assign LOWER_HYST_CODE_OUT = lower_hys_r;
  assign UPPER_HYST_MV_OUT = upper_mv_r;
  assign LOWER_HYST_MV_OUT = lower_mv_r;
  assign RESPONSE_SPEED_OUT = speed_r;
  assign CMP_SYNC_OUT = seen_r;
  assign IRQ_OUT = irq_r;

endmodule : ccr_top

`default_nettype wire

// ### bench/ccr_cmp_model.sv
// Comparator core model with hysteresis.
// Bench sets the input difference in mV.
`timescale 1ns/1ps
`default_nettype none
module ccr_cmp_model (
  input wire logic on_in,
  input wire logic signed [7:0] diff_in,
  input wire logic [4:0] up_in,
  input wire logic [4:0] lo_in,
  output logic out_out
);
  // Holds its level inside the band, as the real core does
  always_latch
    if (!on_in) out_out <= 1'b0;
    else if (diff_in > $signed({3'h0, up_in})) out_out <= 1'b1;
    else if (diff_in < -$signed({3'h0, lo_in})) out_out <= 1'b0;
endmodule : ccr_cmp_model
`default_nettype wire

// ### bench/ccr_top_props.sv
// Port checker for ccr_top, bound below.
// Assumes writes land one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module ccr_top_props (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic [7:0] SFR_PAGE_IN,
  input wire logic SFR_WR_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  input wire logic CMP_ENABLE_OUT,
  input wire logic CMP_POWER_DOWN_OUT,
  input wire logic [4:0] UPPER_HYST_MV_OUT,
  input wire logic [1:0] RESPONSE_SPEED_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_cw; SFR_WR_IN && SFR_ADDR_IN == 8'h9B && SFR_PAGE_IN == 8'h00; endsequence
  sequence s_mw; SFR_WR_IN && SFR_ADDR_IN == 8'h9D; endsequence
  a_pd_tracks_on: assert property (CMP_POWER_DOWN_OUT != CMP_ENABLE_OUT) else $error("pd");
  a_off_powers_down: assert property (s_cw ##0 !SFR_WDATA_IN[7] |=> CMP_POWER_DOWN_OUT) else $error("off");
  a_on_bit_write: assert property (s_cw |=> CMP_ENABLE_OUT == $past(SFR_WDATA_IN[7])) else $error("on");
  a_page_miss_hold: assert property (SFR_WR_IN && SFR_PAGE_IN != 8'h00 |=> $stable(CMP_ENABLE_OUT)) else $error("pg");
  a_up_top_mv: assert property (s_cw ##0 SFR_WDATA_IN[3:2] == 2'h3 |=> UPPER_HYST_MV_OUT == 5'h0A) else $error("top");
  a_up_small_mv: assert property (s_cw ##0 SFR_WDATA_IN[3:2] == 2'h1 |=> UPPER_HYST_MV_OUT == 5'h05) else $error("5");
  a_speed_any_page: assert property (s_mw |=> RESPONSE_SPEED_OUT == $past(SFR_WDATA_IN[1:0])) else $error("sp");
  a_speed_held: assert property (!(SFR_WR_IN && SFR_ADDR_IN == 8'h9D) |=> $stable(RESPONSE_SPEED_OUT)) else $error("sh");
endmodule : ccr_top_props
bind ccr_top ccr_top_props u_props (.MCLK_IN, .RST_N_IN, .SFR_ADDR_IN, .SFR_PAGE_IN, .SFR_WR_IN,
  .SFR_WDATA_IN, .CMP_ENABLE_OUT, .CMP_POWER_DOWN_OUT, .UPPER_HYST_MV_OUT, .RESPONSE_SPEED_OUT);
`default_nettype wire

// ### bench/tb_top.sv
// Bench for ccr_top with the comparator model.
// Needs ccr_top, its checker and the model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, raw, on, pd, irq;
  logic [7:0] adr = 0, pg = 0, wd = 0, rdat, got;
  logic signed [7:0] diff = 0;
  logic [4:0] umv, lmv;
  logic [1:0] spd;
  int miscompares = 0, comparisons = 0, cyc = 0;
  ccr_top u_dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .SFR_ADDR_IN(adr), .SFR_PAGE_IN(pg), .SFR_WR_IN(wr),
    .SFR_RD_IN(rd), .SFR_WDATA_IN(wd), .CMP_RAW_IN(raw), .SFR_RDATA_OUT(rdat), .CMP_ENABLE_OUT(on),
    .CMP_POWER_DOWN_OUT(pd), .UPPER_HYST_CODE_OUT(), .LOWER_HYST_CODE_OUT(), .UPPER_HYST_MV_OUT(umv),
    .LOWER_HYST_MV_OUT(lmv), .RESPONSE_SPEED_OUT(spd), .CMP_SYNC_OUT(), .IRQ_OUT(irq));
  ccr_cmp_model u_cmp (.on_in(on), .diff_in(diff), .up_in(umv), .lo_in(lmv), .out_out(raw));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin miscompares++; wrap_up(); end
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // Strobe held two edges so both comb and registered read data settle
  task automatic acc(input logic w, input logic [7:0] a, p, d);
    @(posedge clk);
    #1 {wr, rd, adr, pg, wd} = {w, !w, a, p, d};
    repeat (2) @(posedge clk);
    #1 got = rdat;
    {wr, rd} = 2'h0;
  endtask : acc
  task automatic sense(input logic signed [7:0] v, input logic [7:0] e);
    diff = v;
    repeat (6) @(posedge clk);
    acc(0, 8'h9B, 8'h00, 8'h00);
    `CHK("ctrl", e, got)
  endtask : sense
  task automatic t_regs();
    acc(0, 8'h9D, 8'h05, 8'h00);
    `CHK("mode", 8'h82, got)
    acc(1, 8'h9D, 8'h07, 8'hFF);
    acc(0, 8'h9D, 8'h00, 8'h00);
    `CHK("mode", 8'hB3, got)
    acc(1, 8'h9B, 8'h01, 8'h80);
    `CHK("page", 1'b0, on)
    for (int i = 0; i < 4; i++) begin
      acc(1, 8'h9D, 8'h00, {6'h20, i[1:0]});
      `CHK("speed", i[1:0], spd)
    end
  endtask : t_regs
  task automatic t_edges();
    acc(1, 8'h9B, 8'h00, 8'h8F);
    `CHK("pd", 1'b0, pd)
    acc(1, 8'h9B, 8'h00, 8'h8F);
    sense(8'sh08, 8'h8F);
    sense(8'sh0F, 8'hEF);
    `CHK("irq", 1'b0, irq)
    acc(1, 8'h9D, 8'h00, 8'hA0);
    `CHK("irq", 1'b1, irq)
    sense(-8'sh0A, 8'hEF);
    sense(-8'sh1E, 8'hBF);
    acc(1, 8'h9B, 8'h00, 8'h87);
    `CHK("irq", 1'b0, irq)
    acc(1, 8'h9B, 8'h00, 8'h07);
    sense(8'sh0F, 8'h07);
    `CHK("pd", 1'b1, pd)
  endtask : t_edges
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    t_regs();
    t_edges();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
